/* File: burner_pkg.sv */
package burner_pkg;

	// clock rate
	localparam int unsigned CLK_HZ = 20_000_000;

	// printed times, in milliseconds
	localparam int unsigned LONG_PRESS_MS = 3000;
	localparam int unsigned FAN_PULSE_MS = 2500;
	localparam int unsigned QUICK_RETRY_MS = 10000;
	localparam int unsigned PREPURGE_MS = 44000;
	localparam int unsigned PREIGN_MS = 3000;
	localparam int unsigned STRAY_MS = 5000;
	localparam int unsigned SAFETY_MS = 3000;
	localparam int unsigned DELAY2_MS = 6000;
	localparam int unsigned AIR_WAIT_MS = 60000;
	localparam int unsigned LAMP_ON_MS = 10000;
	localparam int unsigned LAMP_OFF_MS = 600;

	// cycle counts derived from the times
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned LONG_PRESS_CYC = LONG_PRESS_MS * CYC_PER_MS;
	localparam int unsigned FAN_PULSE_CYC = FAN_PULSE_MS * CYC_PER_MS;
	localparam int unsigned QUICK_RETRY_CYC = QUICK_RETRY_MS * CYC_PER_MS;
	localparam int unsigned PREPURGE_CYC = PREPURGE_MS * CYC_PER_MS;
	localparam int unsigned PREIGN_CYC = PREIGN_MS * CYC_PER_MS;
	localparam int unsigned STRAY_CYC = STRAY_MS * CYC_PER_MS;
	localparam int unsigned SAFETY_CYC = SAFETY_MS * CYC_PER_MS;
	localparam int unsigned DELAY2_CYC = DELAY2_MS * CYC_PER_MS;
	localparam int unsigned AIR_WAIT_CYC = AIR_WAIT_MS * CYC_PER_MS;
	localparam int unsigned LAMP_ON_CYC = LAMP_ON_MS * CYC_PER_MS;
	localparam int unsigned LAMP_OFF_CYC = LAMP_OFF_MS * CYC_PER_MS;

	localparam int CNT_W = 32;

	// lockout causes, also the stored nonvolatile code
	localparam int CAUSE_W = 3;
	localparam logic [2:0] CAUSE_NONE = 3'h0;
	localparam logic [2:0] CAUSE_SAFETY = 3'h1;
	localparam logic [2:0] CAUSE_STRAY = 3'h2;
	localparam logic [2:0] CAUSE_AIR_CLOSED = 3'h3;
	localparam logic [2:0] CAUSE_AIR_TIMEOUT = 3'h4;
	localparam logic [2:0] CAUSE_AIR_OPENED = 3'h5;
	localparam logic [2:0] CAUSE_FLAME_LOSS = 3'h6;
	localparam logic [2:0] CAUSE_MANUAL = 3'h7;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_RESTORE,
		ST_QUICK_FAN,
		ST_QUICK_WAIT,
		ST_AIR_WAIT,
		ST_PREPURGE,
		ST_STRAY,
		ST_PREIGN,
		ST_SAFETY,
		ST_DELAY2,
		ST_RUN,
		ST_UNDERVOLT,
		ST_LOCKOUT
	} seq_state_t;

endpackage : burner_pkg

/* File: burner_supervisor.sv */
`timescale 1ns/10ps

module burner_supervisor
	import burner_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic heat_demand,
	input wire logic button_int,
	input wire logic button_ext,
	input wire logic air_flow_proving_contact,
	input wire logic flame_present,
	input wire logic mains_above_start,
	input wire logic mains_above_hold,
	input wire logic [2:0] nv_cause_in,
	output logic [2:0] nv_cause_out,
	output logic nv_write,
	output logic fan_on,
	output logic ignition_on,
	output logic valve1_on,
	output logic valve2_on,
	output logic alarm_out,
	output logic lamp_on,
	output logic [2:0] lockout_cause,
	output logic [3:0] phase
);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// true on the last cycle of a period of lim cycles
	// counters start at zero, hence the minus one
	function automatic logic expired(input logic [CNT_W-1:0] cnt, input int unsigned lim);
		expired = (cnt >= CNT_W'(lim - 1));
	endfunction : expired

	////////////////////////////////////////////////////////////////////////////
	// pushbutton: both buttons merged, press length measured

	logic button;
	logic button_q_ff;
	logic [CNT_W-1:0] press_cnt_ff;
	logic long_press_ff;
	logic press_edge;
	logic short_release;
	logic long_release;

	assign button = button_int | button_ext;
	assign press_edge = button & ~button_q_ff;
	assign short_release = ~button & button_q_ff & ~long_press_ff;
	assign long_release = ~button & button_q_ff & long_press_ff;

	// press timer; long flag latches once the threshold is passed
	// counter parks at the threshold while held, so a stuck button never wraps
	// short presses never set the flag, so they only matter in lock-out
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			button_q_ff <= 1'b0;
			press_cnt_ff <= '0;
			long_press_ff <= 1'b0;
		end
		else
		begin
			button_q_ff <= button;
			if (!button)
			begin
				press_cnt_ff <= '0;
				long_press_ff <= 1'b0;
			end
			else if (expired(press_cnt_ff, LONG_PRESS_CYC))
				long_press_ff <= 1'b1;
			else
				press_cnt_ff <= press_cnt_ff + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer

	seq_state_t state_ff;
	seq_state_t nxt_state;
	logic [CNT_W-1:0] tmr_ff;
	logic [2:0] cause_ff;
	logic [2:0] nxt_cause;
	logic second_try_ff;
	logic nxt_second_try;
	logic boot_ff;
	logic active;

	// start and run phases, where under-voltage and long presses apply
	// idle, restore, quick retry and lock-out ignore both on purpose:
	// a lock-out must survive a mains dip and only a press edge clears it
	assign active = (state_ff == ST_AIR_WAIT) || (state_ff == ST_PREPURGE) ||
		(state_ff == ST_STRAY) || (state_ff == ST_PREIGN) ||
		(state_ff == ST_SAFETY) || (state_ff == ST_DELAY2) || (state_ff == ST_RUN);

	always_comb
	begin
		nxt_state = state_ff;
		nxt_cause = cause_ff;
		nxt_second_try = second_try_ff;
		case (state_ff)
			ST_IDLE:
			begin
				nxt_second_try = 1'b0;
				if (heat_demand && mains_above_start)
				begin
					if (air_flow_proving_contact)
						nxt_state = ST_QUICK_FAN;
					else
						nxt_state = ST_AIR_WAIT;
				end
			end
			ST_RESTORE:
				if (expired(tmr_ff, FAN_PULSE_CYC))
					nxt_state = ST_LOCKOUT;
			ST_QUICK_FAN:
				if (expired(tmr_ff, FAN_PULSE_CYC))
				begin
					if (!second_try_ff)
						nxt_state = ST_QUICK_WAIT;
					else if (air_flow_proving_contact)
					begin
						nxt_state = ST_LOCKOUT;
						nxt_cause = CAUSE_AIR_CLOSED;
					end
					else
						nxt_state = ST_AIR_WAIT;
				end
			ST_QUICK_WAIT:
				if (expired(tmr_ff, QUICK_RETRY_CYC))
				begin
					nxt_state = ST_QUICK_FAN;
					nxt_second_try = 1'b1;
				end
			ST_AIR_WAIT:
				if (air_flow_proving_contact)
					nxt_state = ST_PREPURGE;
				else if (expired(tmr_ff, AIR_WAIT_CYC))
				begin
					nxt_state = ST_LOCKOUT;
					nxt_cause = CAUSE_AIR_TIMEOUT;
				end
			ST_PREPURGE:
				if (!air_flow_proving_contact)
				begin
					nxt_state = ST_LOCKOUT;
					nxt_cause = CAUSE_AIR_OPENED;
				end
				else if (expired(tmr_ff, PREPURGE_CYC))
					nxt_state = ST_STRAY;
			ST_STRAY:
				if (flame_present)
				begin
					nxt_state = ST_LOCKOUT;
					nxt_cause = CAUSE_STRAY;
				end
				else if (!air_flow_proving_contact)
				begin
					nxt_state = ST_LOCKOUT;
					nxt_cause = CAUSE_AIR_OPENED;
				end
				else if (expired(tmr_ff, STRAY_CYC))
					nxt_state = ST_PREIGN;
			ST_PREIGN:
				if (expired(tmr_ff, PREIGN_CYC))
					nxt_state = ST_SAFETY;
			ST_SAFETY:
				if (expired(tmr_ff, SAFETY_CYC))
				begin
					if (flame_present)
						nxt_state = ST_DELAY2;
					else
					begin
						nxt_state = ST_LOCKOUT;
						nxt_cause = CAUSE_SAFETY;
					end
				end
			ST_DELAY2, ST_RUN:
				if (!air_flow_proving_contact)
				begin
					nxt_state = ST_LOCKOUT;
					nxt_cause = CAUSE_AIR_OPENED;
				end
				else if (!flame_present)
				begin
					nxt_state = ST_LOCKOUT;
					nxt_cause = CAUSE_FLAME_LOSS;
				end
				else if (state_ff == ST_DELAY2 && expired(tmr_ff, DELAY2_CYC))
					nxt_state = ST_RUN;
				else if (state_ff == ST_RUN && !heat_demand)
					nxt_state = ST_IDLE; // controlled shutdown
			ST_UNDERVOLT:
				if (mains_above_start)
					nxt_state = ST_IDLE;
			ST_LOCKOUT:
				if (press_edge)
				begin
					nxt_state = ST_IDLE;
					nxt_cause = CAUSE_NONE;
				end
			default:
				nxt_state = ST_IDLE;
		endcase
		// supervision that overrides every start and run phase
		// a fault seen in the same cycle is dropped, else a stale cause
		// would be stored and shown after the automatic restart
		if (active && !mains_above_hold)
		begin
			nxt_state = ST_UNDERVOLT;
			nxt_cause = cause_ff;
		end
		else if (active && long_release)
		begin
			nxt_state = ST_IDLE;
			nxt_cause = cause_ff;
		end
		// short presses fall through untouched
		if (active && short_release)
			nxt_state = nxt_state;
	end

	// state, phase timer and cause registers
	// the stored cause is read once only: later store writes must not loop back
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff <= ST_IDLE;
			tmr_ff <= '0;
			cause_ff <= CAUSE_NONE;
			second_try_ff <= 1'b0;
			boot_ff <= 1'b1;
		end
		else
		begin
			boot_ff <= 1'b0;
			second_try_ff <= nxt_second_try;
			// stored cause taken once after reset release
			if (boot_ff && nv_cause_in != CAUSE_NONE)
			begin
				state_ff <= ST_RESTORE;
				cause_ff <= nv_cause_in;
				tmr_ff <= '0;
			end
			else if (!boot_ff)
			begin
				state_ff <= nxt_state;
				cause_ff <= nxt_cause;
				tmr_ff <= (nxt_state != state_ff) ? '0 : tmr_ff + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// nonvolatile cause store: one write per cause change
	// a strobe per change only, to spare the store's write endurance
	// the write strobe rises on the same edge as the state change

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			nv_write <= 1'b0;
			nv_cause_out <= CAUSE_NONE;
		end
		else
		begin
			nv_write <= !boot_ff && (nxt_cause != cause_ff);
			nv_cause_out <= nxt_cause;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// lock-out lamp: steady for ten seconds, then a short dark gap, repeating every 10.6 seconds
	// only the gap is made here; the cause code in it is left to the display

	logic [CNT_W-1:0] lamp_cnt_ff;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			lamp_cnt_ff <= '0;
		else if (state_ff != ST_LOCKOUT ||
			expired(lamp_cnt_ff, LAMP_ON_CYC + LAMP_OFF_CYC))
			lamp_cnt_ff <= '0;
		else
			lamp_cnt_ff <= lamp_cnt_ff + 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	// registered outputs
	// all commands and phase come from the same state, so they stay aligned
	// the registered stage keeps decode glitches off the relay drivers

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fan_on <= 1'b0;
			ignition_on <= 1'b0;
			valve1_on <= 1'b0;
			valve2_on <= 1'b0;
			alarm_out <= 1'b0;
			lamp_on <= 1'b0;
			lockout_cause <= CAUSE_NONE;
			phase <= 4'h0;
		end
		else
		begin
			fan_on <= (state_ff == ST_RESTORE) || (state_ff == ST_QUICK_FAN) ||
				(state_ff == ST_AIR_WAIT) || (state_ff == ST_PREPURGE) ||
				(state_ff == ST_STRAY) || (state_ff == ST_PREIGN) ||
				(state_ff == ST_SAFETY) || (state_ff == ST_DELAY2) ||
				(state_ff == ST_RUN);
			ignition_on <= (state_ff == ST_PREIGN) || (state_ff == ST_SAFETY);
			valve1_on <= (state_ff == ST_SAFETY) || (state_ff == ST_DELAY2) ||
				(state_ff == ST_RUN);
			valve2_on <= (state_ff == ST_RUN);
			alarm_out <= (state_ff == ST_LOCKOUT);
			lamp_on <= (state_ff == ST_LOCKOUT) &&
				!expired(lamp_cnt_ff, LAMP_ON_CYC);
			lockout_cause <= cause_ff;
			phase <= state_ff;
		end
	end

endmodule : burner_supervisor

/* File: burner_checker.sv */
`timescale 1ns/10ps

module burner_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic heat_demand,
	input wire logic air_flow_proving_contact,
	input wire logic flame_present,
	input wire logic mains_above_start,
	input wire logic mains_above_hold,
	input wire logic nv_write,
	input wire logic ignition_on,
	input wire logic valve1_on,
	input wire logic alarm_out,
	input wire logic [2:0] lockout_cause,
	input wire logic [3:0] phase
);
	// one domain, so one clock and one reset for every property
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////
	lock_alarm_a: assert property (phase == 4'hc && $past(phase) == 4'hc |-> alarm_out)
		else $error("alarm low while locked out");
	cause_hold_a: assert property (phase == 4'hc && $past(phase) == 4'hc |-> $stable(lockout_cause))
		else $error("cause changed while locked out");
	nv_store_a: assert property (phase == 4'hc && $past(phase) == 4'h5 |-> (nv_write || $past(nv_write)) or ##1 nv_write)
		else $error("cause not stored on lockout");
	write_pulse_a: assert property (nv_write |=> !nv_write)
		else $error("store strobe longer than one cycle");
	// phase and outputs come from the same state register; either cycle is accepted all the same
	ign_phase_a: assert property (ignition_on |-> phase inside {[7:8]} || $past(phase) inside {[7:8]})
		else $error("ignition outside ignition phases");
	valve_phase_a: assert property (valve1_on |-> phase inside {[8:10]} || $past(phase) inside {[8:10]})
		else $error("valve open before safety time");
	// only real start-ups count; the power-return restore needs no mains check
	start_mains_a: assert property ($past(phase) == 4'h0 && phase inside {4'h2, 4'h4} |-> $past(mains_above_start) || $past(mains_above_start, 2))
		else $error("start with low mains");
	undervolt_a: assert property (!mains_above_hold && phase inside {[4:10]} |-> ##[1:2] phase inside {4'hb, 4'hc})
		else $error("no stop on mains drop");
	air_open_a: assert property (phase == 4'h5 && !air_flow_proving_contact |-> ##[1:2] phase == 4'hc)
		else $error("air loss in pre-purge not locked out");
	flame_loss_a: assert property (phase == 4'ha && heat_demand && !flame_present |-> ##[1:2] phase == 4'hc)
		else $error("flame loss in run not locked out");
	revive_a: assert property (phase == 4'hb && mains_above_start |-> ##[1:2] phase != 4'hb)
		else $error("no restart after mains recovery");
endmodule : burner_checker

/* File: burner_plant.sv */
`timescale 1ns/10ps

module burner_plant (
	input wire logic clk,
	input wire logic [2:0] nv_cause_out,
	input wire logic nv_write,
	output logic heat_demand,
	output logic button_int,
	output logic button_ext,
	output logic air_flow_proving_contact,
	output logic flame_present,
	output logic mains_above_start,
	output logic mains_above_hold,
	output logic [2:0] nv_cause_in
);
	int volts = 230;
	logic [2:0] nv_mem_ff = 3'h0;

	// two comparators; between 160 and 187 only the hold one is high
	assign mains_above_start = volts > 187;
	assign mains_above_hold = volts >= 160;
	assign nv_cause_in = nv_mem_ff;
	// nonvolatile store, never cleared by the bench reset
	always @(posedge clk)
		if (nv_write)
			nv_mem_ff <= nv_cause_out;

	task automatic set_env(input logic d, input logic a, input logic f, input int v);
		// demand drops in the lock-out and restore scenarios; runs last far less than a day
		heat_demand = d;
		air_flow_proving_contact = a;
		flame_present = f;
		volts = v;
	endtask : set_env

	task automatic press(input logic ext, input int n);
		button_ext = ext;
		button_int = !ext;
		repeat (n) @(posedge clk);
		#1;
		button_ext = 1'b0;
		button_int = 1'b0;
	endtask : press

	initial
	begin
		set_env(1'b0, 1'b0, 1'b0, 230);
		button_int = 1'b0;
		button_ext = 1'b0;
	end
endmodule : burner_plant

/* File: burner_supervisor_test.sv */
`timescale 1ns/10ps

module burner_supervisor_test;
	import burner_pkg::*;
	logic clk, rst_n, heat_demand, button_int, button_ext, air_flow_proving_contact;
	logic flame_present, mains_above_start, mains_above_hold, nv_write, fan_on;
	logic ignition_on, valve1_on, valve2_on, alarm_out, lamp_on;
	logic [2:0] nv_cause_in, nv_cause_out, lockout_cause;
	logic [3:0] phase;
	int error_cnt = 0;
	int n_compared = 0;

	burner_supervisor u_dut (.clk(clk), .rst_n(rst_n), .heat_demand(heat_demand),
		.button_int(button_int), .button_ext(button_ext),
		.air_flow_proving_contact(air_flow_proving_contact), .flame_present(flame_present),
		.mains_above_start(mains_above_start), .mains_above_hold(mains_above_hold),
		.nv_cause_in(nv_cause_in), .nv_cause_out(nv_cause_out), .nv_write(nv_write),
		.fan_on(fan_on), .ignition_on(ignition_on), .valve1_on(valve1_on),
		.valve2_on(valve2_on), .alarm_out(alarm_out), .lamp_on(lamp_on),
		.lockout_cause(lockout_cause), .phase(phase));
	burner_plant u_plant (.clk(clk), .nv_cause_out(nv_cause_out), .nv_write(nv_write),
		.heat_demand(heat_demand), .button_int(button_int), .button_ext(button_ext),
		.air_flow_proving_contact(air_flow_proving_contact), .flame_present(flame_present),
		.mains_above_start(mains_above_start), .mains_above_hold(mains_above_hold),
		.nv_cause_in(nv_cause_in));

	// 20 MHz
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic [3:0] got, input logic [3:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	// inputs always move 1 ns after the rising edge
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	// bounded wait; running out ends the run
	task automatic wait_phase(input logic [3:0] p);
		for (int i = 0; i < 300 && phase !== p; i++)
			step(1);
		check(phase, p);
		if (phase !== p)
			tally_and_finish();
	endtask : wait_phase

	task automatic do_reset;
		rst_n = 1'b0;
		step(3);
		rst_n = 1'b1;
		step(2);
	endtask : do_reset

	////////////////////////////////////////////////////////////////
	task automatic t_mains;
		u_plant.set_env(1'b1, 1'b0, 1'b0, 170);
		step(20);
		check(phase, 4'h0);
		u_plant.set_env(1'b1, 1'b0, 1'b0, 230);
		wait_phase(4'h4);
		step(1);
		check(fan_on, 1'b1);
		// no ignition, fuel or lamp while waiting for air
		check(ignition_on, 1'b0);
		check(valve1_on, 1'b0);
		check(valve2_on, 1'b0);
		check(lamp_on, 1'b0);
	endtask : t_mains

	// 170 V lies in the band: no stop; 150 V stops, recovery restarts alone
	task automatic t_undervolt;
		u_plant.set_env(1'b1, 1'b0, 1'b0, 170);
		step(20);
		check(phase, 4'h4);
		u_plant.set_env(1'b1, 1'b0, 1'b0, 150);
		wait_phase(4'hb);
		step(2);
		check(fan_on, 1'b0);
		u_plant.set_env(1'b1, 1'b0, 1'b0, 230);
		wait_phase(4'h4);
	endtask : t_undervolt

	task automatic t_air_lock(input logic ext);
		u_plant.set_env(1'b1, 1'b0, 1'b0, 230);
		wait_phase(4'h4);
		u_plant.set_env(1'b1, 1'b1, 1'b0, 230);
		wait_phase(4'h5);
		u_plant.press(ext, 100);
		step(5);
		check(phase, 4'h5);
		u_plant.set_env(1'b1, 1'b0, 1'b0, 230);
		wait_phase(4'hc);
		step(3);
		check(lockout_cause, CAUSE_AIR_OPENED);
		check(u_plant.nv_mem_ff, CAUSE_AIR_OPENED);
		step(300);
		check(alarm_out, 1'b1);
		check(lamp_on, 1'b1);
		u_plant.set_env(1'b0, 1'b0, 1'b0, 230);
		u_plant.press(ext, 10);
		wait_phase(4'h0);
		step(3);
		check(alarm_out, 1'b0);
		check(lamp_on, 1'b0);
		check(u_plant.nv_mem_ff, CAUSE_NONE);
	endtask : t_air_lock

	task automatic t_quick;
		u_plant.set_env(1'b1, 1'b1, 1'b0, 230);
		wait_phase(4'h2);
		step(2);
		check(fan_on, 1'b1);
	endtask : t_quick

	// stored cause survives power loss: fan first, not idle
	task automatic t_restore;
		u_plant.set_env(1'b0, 1'b0, 1'b0, 230);
		u_plant.nv_mem_ff = CAUSE_FLAME_LOSS;
		do_reset();
		check(phase, 4'h1);
		step(2);
		check(fan_on, 1'b1);
		check(alarm_out, 1'b0);
	endtask : t_restore

	initial
	begin
		rst_n = 1'b0;
		do_reset();
		check(phase, 4'h0);
		t_mains();
		t_undervolt();
		t_air_lock(1'b0);
		t_air_lock(1'b1);
		t_quick();
		t_restore();
		tally_and_finish();
	end
endmodule : burner_supervisor_test

bind burner_supervisor burner_checker u_chk (.clk(clk), .rst_n(rst_n),
	.heat_demand(heat_demand), .air_flow_proving_contact(air_flow_proving_contact),
	.flame_present(flame_present), .mains_above_start(mains_above_start),
	.mains_above_hold(mains_above_hold), .nv_write(nv_write), .ignition_on(ignition_on),
	.valve1_on(valve1_on), .alarm_out(alarm_out), .lockout_cause(lockout_cause),
	.phase(phase));
